// *** hdl/lsc_config_regs.sv ***
/*
 Configuration register pair for a four-sink LED driver, with unlock gate
 and decoded settings for the analog and PWM logic.
 Assumes a one-cycle strobe master on clock_in and synchronous reset.
*/
`timescale 1ns/1ps
module lsc_config_regs
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire lsc_pkg::lsc_bus_t bus_in,
    output logic [7:0] rdata_out,
    output logic unlocked_out,
    output lsc_pkg::lsc_cfg_t cfg_out
);
    import lsc_pkg::*;

    logic [7:0] setup_reg;
    logic [7:0] fault_reg;
    logic extres_reg;
    lsc_lock_t lock_reg;
    lsc_lock_t lock_next;
    logic wr_setup;
    logic wr_fault;
    logic wr_unlock;
    lsc_cfg_t cfg_next;

    // -----------------------------------------------------------------
    // Unlock sequence
    // -----------------------------------------------------------------
    assign wr_unlock = bus_in.wr && (bus_in.addr == LSC_UNLOCK_OFS);

    always_comb
    begin
        lock_next = lock_reg;
        if (wr_unlock)
        begin
            case (lock_reg)
                LSC_LK_LOCKED: lock_next = (bus_in.wdata == LSC_UNLOCK_CODE0) ? LSC_LK_GOT1 : LSC_LK_LOCKED;
                LSC_LK_GOT1: lock_next = (bus_in.wdata == LSC_UNLOCK_CODE1) ? LSC_LK_GOT2 : LSC_LK_LOCKED;
                LSC_LK_GOT2: lock_next = (bus_in.wdata == LSC_UNLOCK_CODE2) ? LSC_LK_OPEN : LSC_LK_LOCKED;
                LSC_LK_OPEN: lock_next = LSC_LK_LOCKED;
                default: lock_next = LSC_LK_LOCKED;
            endcase
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
            lock_reg <= LSC_LK_LOCKED;
        else
            lock_reg <= lock_next;
    end

    // -----------------------------------------------------------------
    // Stored fields
    // -----------------------------------------------------------------
    assign wr_setup = bus_in.wr && (bus_in.addr == LSC_SETUP_OFS) && (lock_reg == LSC_LK_OPEN);
    assign wr_fault = bus_in.wr && (bus_in.addr == LSC_FAULT_OFS) && (lock_reg == LSC_LK_OPEN);

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
            setup_reg <= LSC_SETUP_RST;
        else if (wr_setup)
            setup_reg <= bus_in.wdata;
    end

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
            fault_reg <= LSC_FAULT_RST;
        else if (wr_fault)
            fault_reg <= bus_in.wdata;
    end

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
            extres_reg <= 1'b0;
        else if (bus_in.wr && (bus_in.addr == LSC_CTRL_OFS) && (lock_reg == LSC_LK_OPEN))
            extres_reg <= bus_in.wdata[LSC_EXTRES_BIT];
    end

    // -----------------------------------------------------------------
    // Read port
    // -----------------------------------------------------------------
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
            rdata_out <= 8'h00;
        else if (bus_in.rd)
        begin
            case (bus_in.addr)
                LSC_SETUP_OFS: rdata_out <= setup_reg;
                LSC_FAULT_OFS: rdata_out <= fault_reg;
                LSC_CTRL_OFS: rdata_out <= {7'h00, extres_reg};
                LSC_STATUS_OFS: rdata_out <= {6'h00, lock_reg};
                default: rdata_out <= 8'h00;
            endcase
        end
        else
            rdata_out <= 8'h00;
    end

    // -----------------------------------------------------------------
    // Decode of settings
    // -----------------------------------------------------------------
    always_comb
    begin
        cfg_next = '0;
        cfg_next.display_fault_enable = setup_reg[LSC_DISP_FAULT_BIT];
        cfg_next.hybrid_dimming = setup_reg[LSC_HYBRID_BIT];
        cfg_next.cluster_fault_enable = fault_reg[LSC_CL_FAULT_BIT];
        cfg_next.full_scale_current_code = setup_reg[LSC_SCALE_LSB +: 3];
        cfg_next.use_external_resistor = extres_reg;
        if (extres_reg)
            cfg_next.scale_ma = 16'h0000;
        else
        begin
            case (setup_reg[LSC_SCALE_LSB +: 3])
                3'h0: cfg_next.scale_ma = 16'd25;
                3'h1: cfg_next.scale_ma = 16'd30;
                3'h2: cfg_next.scale_ma = 16'd50;
                3'h3: cfg_next.scale_ma = 16'd60;
                3'h4: cfg_next.scale_ma = 16'd80;
                3'h5: cfg_next.scale_ma = 16'd100;
                3'h6: cfg_next.scale_ma = 16'd120;
                default: cfg_next.scale_ma = 16'd150;
            endcase
        end
        // Group mask: sinks driven as display strings; rest go to cluster
        case (setup_reg[LSC_GROUP_LSB +: 3])
            3'h0:
            begin
                cfg_next.sink_group_mask = 4'hF;
                cfg_next.phase_step = 2'd1;
            end
            3'h1:
            begin
                cfg_next.sink_group_mask = 4'h7;
                cfg_next.phase_step = 2'd2;
            end
            3'h2:
            begin
                cfg_next.sink_group_mask = 4'h3;
                cfg_next.phase_step = 2'd3;
            end
            3'h3:
            begin
                cfg_next.sink_group_mask = 4'h1;
                cfg_next.phase_step = 2'd0;
            end
            3'h4:
            begin
                cfg_next.sink_group_mask = 4'hF;
                cfg_next.phase_step = 2'd3;
            end
            3'h5:
            begin
                cfg_next.sink_group_mask = 4'hF;
                cfg_next.phase_step = 2'd0;
            end
            3'h6:
            begin
                cfg_next.sink_group_mask = 4'h3;
                cfg_next.phase_step = 2'd0;
            end
            default:
            begin
                cfg_next.sink_group_mask = 4'h0;
                cfg_next.phase_step = 2'd0;
            end
        endcase
        cfg_next.sink_cluster_mask = ~cfg_next.sink_group_mask;
        case (fault_reg[LSC_GAP_LSB +: 2])
            2'h0: cfg_next.comparator_gap_mv = 11'd1000;
            2'h1: cfg_next.comparator_gap_mv = 11'd750;
            2'h2: cfg_next.comparator_gap_mv = 11'd500;
            default: cfg_next.comparator_gap_mv = 11'd250;
        endcase
        case (fault_reg[LSC_THR_LSB +: 2])
            2'h2: cfg_next.short_threshold_dv = 7'd69;
            2'h3: cfg_next.short_threshold_dv = 7'd106;
            default: cfg_next.short_threshold_dv = 7'd36;
        endcase
        case (fault_reg[LSC_HEAD_LSB +: 3])
            3'h7: cfg_next.headroom_mv = 10'd50;
            3'h6: cfg_next.headroom_mv = 10'd175;
            3'h5: cfg_next.headroom_mv = 10'd300;
            3'h4: cfg_next.headroom_mv = 10'd450;
            3'h3: cfg_next.headroom_mv = 10'd575;
            3'h2: cfg_next.headroom_mv = 10'd700;
            3'h1: cfg_next.headroom_mv = 10'd875;
            default: cfg_next.headroom_mv = 10'd1000;
        endcase
    end

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            cfg_out <= '0;
            unlocked_out <= 1'b0;
        end
        else
        begin
            cfg_out <= cfg_next;
            unlocked_out <= (lock_next == LSC_LK_OPEN);
        end
    end
endmodule // lsc_config_regs

// *** hdl/lsc_pkg.sv ***
/*
 Package for the LED sink configuration register pair: offsets, fields,
 reset values, unlock codes and decoded types.
 Assumes a byte-wide register port with byte offsets.
*/
// How it works
// - Display string open/short fault reporting allowed only when setup bit 7 is set.
// - Setup bits 6:4 pick full-scale current code, 25 mA up to 150 mA.
// - Grouping codes 0-3 run four to one separate phase-shifted strings.
// - Codes 4, 5, 6 tie sinks in pairs, all four, or 1+2.
// - Grouping code 7 puts every sink in cluster mode.
// - Setup bit 0 enables hybrid PWM and current dimming.
// - Fault register bit 7 enables cluster string open/short faults.
// - Fault bits 6:5 set comparator gap 1000, 750, 500, 250 mV.
// - Fault bits 4:3 select short threshold: 3.6, 3.6, 6.9, 10.6 V.
// - Fault bits 2:0 set headroom, inversely ordered, 111 smallest.
// - External resistor enable ignores the scale code; otherwise the code applies.
package lsc_pkg;
    // -----------------------------------------------------------------
    // Register map
    // -----------------------------------------------------------------
    localparam logic [7:0] LSC_UNLOCK_OFS = 8'h1A;
    localparam logic [7:0] LSC_CTRL_OFS = 8'h1B;
    localparam logic [7:0] LSC_STATUS_OFS = 8'h1C;
    localparam logic [7:0] LSC_SETUP_OFS = 8'h63;
    localparam logic [7:0] LSC_FAULT_OFS = 8'h64;
    localparam logic [7:0] LSC_SETUP_RST = 8'h00;
    localparam logic [7:0] LSC_FAULT_RST = 8'h00;
    localparam logic [7:0] LSC_UNLOCK_CODE0 = 8'h08;
    localparam logic [7:0] LSC_UNLOCK_CODE1 = 8'hBA;
    localparam logic [7:0] LSC_UNLOCK_CODE2 = 8'hEF;
    // -----------------------------------------------------------------
    // Field positions
    // -----------------------------------------------------------------
    localparam int LSC_DISP_FAULT_BIT = 7;
    localparam int LSC_SCALE_LSB = 4;
    localparam int LSC_GROUP_LSB = 1;
    localparam int LSC_HYBRID_BIT = 0;
    localparam int LSC_CL_FAULT_BIT = 7;
    localparam int LSC_GAP_LSB = 5;
    localparam int LSC_THR_LSB = 3;
    localparam int LSC_HEAD_LSB = 0;
    localparam int LSC_EXTRES_BIT = 0;

    typedef enum logic [1:0] {
        LSC_LK_LOCKED = 2'b00,
        LSC_LK_GOT1 = 2'b01,
        LSC_LK_GOT2 = 2'b10,
        LSC_LK_OPEN = 2'b11
    } lsc_lock_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } lsc_bus_t;

    typedef struct packed {
        logic display_fault_enable;
        logic cluster_fault_enable;
        logic hybrid_dimming;
        logic [2:0] full_scale_current_code;
        logic use_external_resistor;
        logic [15:0] scale_ma;
        logic [3:0] sink_group_mask;
        logic [3:0] sink_cluster_mask;
        logic [1:0] phase_step;
        logic [10:0] comparator_gap_mv;
        logic [6:0] short_threshold_dv;
        logic [9:0] headroom_mv;
    } lsc_cfg_t;
endpackage : lsc_pkg

// *** sim/lsc_config_regs_sva.sv ***
/*
 Checker for the LED sink configuration registers.
 Assumes the top module's ports only; bound below.
*/
`timescale 1ns/1ps
module lsc_config_regs_sva
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire lsc_pkg::lsc_bus_t bus_in,
    input wire logic [7:0] rdata_out,
    input wire logic unlocked_out,
    input wire lsc_pkg::lsc_cfg_t cfg_out
);
    import lsc_pkg::*;
    localparam logic [15:0] SC [8] = '{25, 30, 50, 60, 80, 100, 120, 150};
    wire wr_s = bus_in.wr && bus_in.addr == 8'h63;
    wire wr_f = bus_in.wr && bus_in.addr == 8'h64;
    wire wr_k = bus_in.wr && bus_in.addr == 8'h1A;
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    property p_rd_idle; !$past(bus_in.rd) |-> rdata_out == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    property p_back; wr_s && unlocked_out ##1 bus_in.rd && bus_in.addr == 8'h63
        |=> rdata_out == $past(bus_in.wdata, 2); endproperty
    a_back: assert property (p_back) else $error("readback differs");
    property p_locked; !unlocked_out && (wr_s || wr_f) |-> ##2 $stable(cfg_out); endproperty
    a_locked: assert property (p_locked) else $error("locked write took effect");
    property p_unlock; !unlocked_out && wr_k && bus_in.wdata == 8'h08 ##1 wr_k && bus_in.wdata == 8'hBA
        ##1 wr_k && bus_in.wdata == 8'hEF |=> unlocked_out; endproperty
    a_unlock: assert property (p_unlock) else $error("sequence did not unlock");
    property p_relock; unlocked_out && wr_k |=> !unlocked_out; endproperty
    a_relock: assert property (p_relock) else $error("no relock");
    property p_ext; cfg_out.use_external_resistor |-> cfg_out.scale_ma == 16'h0000; endproperty
    a_ext: assert property (p_ext) else $error("scale code not ignored");
    property p_scale; wr_s && unlocked_out && !cfg_out.use_external_resistor
        |-> ##2 cfg_out.scale_ma == SC[$past(bus_in.wdata[6:4], 2)]; endproperty
    a_scale: assert property (p_scale) else $error("wrong full scale");
    property p_mask; wr_s && unlocked_out |-> ##2 cfg_out.sink_cluster_mask == ~cfg_out.sink_group_mask; endproperty
    a_mask: assert property (p_mask) else $error("cluster mask mismatch");
    property p_setup; wr_s && unlocked_out |-> ##2 cfg_out.display_fault_enable == $past(bus_in.wdata[7], 2)
        && cfg_out.hybrid_dimming == $past(bus_in.wdata[0], 2); endproperty
    a_setup: assert property (p_setup) else $error("setup flags wrong");
    property p_gap; wr_f && unlocked_out
        |-> ##2 cfg_out.comparator_gap_mv == 11'h3E8 - 11'h0FA * $past(bus_in.wdata[6:5], 2); endproperty
    a_gap: assert property (p_gap) else $error("wrong gap");
    property p_clf; wr_f && unlocked_out |-> ##2 cfg_out.cluster_fault_enable == $past(bus_in.wdata[7], 2); endproperty
    a_clf: assert property (p_clf) else $error("cluster fault flag wrong");
endmodule // lsc_config_regs_sva

bind lsc_config_regs lsc_config_regs_sva u_sva (.clock_in(clock_in), .rst_in(rst_in), .bus_in(bus_in),
    .rdata_out(rdata_out), .unlocked_out(unlocked_out), .cfg_out(cfg_out));

// *** sim/led_sink_config_regs_tb_top.sv ***
/*
 Testbench for the LED sink configuration registers.
 Assumes the design package and the bound checker.
*/
`timescale 1ns/1ps
module led_sink_config_regs_tb_top;
    import lsc_pkg::*;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    lsc_bus_t bus_in = '0;
    logic [7:0] rdata_out;
    logic unlocked_out;
    lsc_cfg_t cfg_out;
    logic [7:0] v;
    int n_errors = 0;
    int n_compared = 0;
    int cyc = 0;
    localparam logic [15:0] SC [8] = '{25, 30, 50, 60, 80, 100, 120, 150};
    localparam logic [3:0] GM [8] = '{4'hF, 4'h7, 4'h3, 4'h1, 4'hF, 4'hF, 4'h3, 4'h0};
    localparam logic [1:0] PH [8] = '{1, 2, 3, 0, 3, 0, 0, 0};
    localparam logic [9:0] HD [8] = '{1000, 875, 700, 575, 450, 300, 175, 50};
    localparam logic [6:0] TH [4] = '{36, 36, 69, 106};
    lsc_config_regs uut (.clock_in(clock_in), .rst_in(rst_in), .bus_in(bus_in), .rdata_out(rdata_out),
        .unlocked_out(unlocked_out), .cfg_out(cfg_out));
    initial forever #50 clock_in = ~clock_in;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus_in <= '{a, d, 1'b1, 1'b0};
        @(posedge clock_in);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        bus_in <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clock_in);
        bus_in <= '0;
        @(negedge clock_in);
        chk(rdata_out, e);
        @(posedge clock_in);
    endtask
    task automatic wrap_up();
        $display("compared=%0d errors=%0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Cut a hang short
    always @(posedge clock_in)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            n_errors++;
            wrap_up();
        end
    end
    initial
    begin
        repeat (4) @(posedge clock_in);
        rst_in <= 1'b0;
        repeat (2) @(posedge clock_in);
        rd(8'h64, 8'h00);
        wr(8'h63, 8'hA5);
        rd(8'h63, 8'h00);
        wr(8'h1A, 8'h08);
        rd(8'h1C, 8'h01);
        wr(8'h1A, 8'h08);
        wr(8'h1A, 8'hEF);
        rd(8'h1C, 8'h00);
        wr(8'h1A, 8'h08);
        wr(8'h1A, 8'hBA);
        wr(8'h1A, 8'hEF);
        rd(8'h1C, 8'h03);
        chk(unlocked_out, 1'b1);
        for (int i = 0; i < 8; i++)
        begin
            v = {i[0], i[2:0], i[2:0], ~i[0]};
            wr(8'h63, v);
            rd(8'h63, v);
            chk(cfg_out.scale_ma, SC[i]);
            chk(cfg_out.full_scale_current_code, i[2:0]);
            chk(cfg_out.sink_cluster_mask, 4'(~GM[i]));
            chk(cfg_out.sink_group_mask, GM[i]);
            chk(cfg_out.phase_step, PH[i]);
            chk({cfg_out.display_fault_enable, cfg_out.hybrid_dimming}, {v[7], v[0]});
            v = {~i[0], i[1:0], i[1:0], i[2:0]};
            wr(8'h64, v);
            rd(8'h64, v);
            chk(cfg_out.headroom_mv, HD[i]);
            chk(cfg_out.short_threshold_dv, TH[i % 4]);
            chk(cfg_out.comparator_gap_mv, 11'(1000 - 250 * (i % 4)));
            chk(cfg_out.cluster_fault_enable, v[7]);
        end
        wr(8'h1B, 8'h01);
        rd(8'h1B, 8'h01);
        chk(cfg_out.scale_ma, 16'h0000);
        chk(cfg_out.use_external_resistor, 1'b1);
        wr(8'h1B, 8'h00);
        rd(8'h1B, 8'h00);
        chk(cfg_out.scale_ma, SC[7]);
        chk(cfg_out.use_external_resistor, 1'b0);
        wr(8'h1A, 8'h00);
        wr(8'h63, 8'h00);
        chk(unlocked_out, 1'b0);
        rd(8'h63, 8'hFE);
        wr(8'h70, 8'h55);
        rd(8'h70, 8'h00);
        wrap_up();
    end
endmodule // led_sink_config_regs_tb_top
